// File: core/ait_pkg.sv
// Shared constants and types for the converter's two-wire serial target
// and for the bus controller that talks to it.
// Assumes both ends meet on one open-drain bus carried by ait_bus_if.

package ait_pkg;

  // Byte and address layout on the bus.
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] TGT_ADDR = 7'h30;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // Timing: system clock period and fastest bus clock period.
  localparam int SYS_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 1000;
  // A quarter bus period rounds up, so the rate never exceeds 1 Mbit/s.
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * SYS_PERIOD_NS - 1) /
                           (4 * SYS_PERIOD_NS);
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
  // Master clock cycles that ready stays high before a data update.
  localparam logic [2:0] PRE_UPDATE_MCLK = 3'h4;

  // Controller commands.
  typedef enum logic [1:0] {
    AIT_CMD_START = 2'b00,
    AIT_CMD_WRITE = 2'b01,
    AIT_CMD_READ  = 2'b10,
    AIT_CMD_STOP  = 2'b11
  } ait_cmd_e;

  // Target states.
  typedef enum logic [2:0] {
    AIT_T_IDLE  = 3'b000,
    AIT_T_ADDR  = 3'b001,
    AIT_T_ACK   = 3'b010,
    AIT_T_RX    = 3'b011,
    AIT_T_TX    = 3'b100,
    AIT_T_TXACK = 3'b101
  } ait_tgt_st_e;

  // Controller states.
  typedef enum logic [1:0] {
    AIT_C_IDLE  = 2'b00,
    AIT_C_START = 2'b01,
    AIT_C_STOP  = 2'b10,
    AIT_C_BIT   = 2'b11
  } ait_ctl_st_e;

  // True when an address byte selects this target; general call never does.
  function automatic logic ait_addr_hit(input logic [7:0] byte_in,
                                        input logic [6:0] own);
    return (byte_in[7:1] == own) && (byte_in[7:1] != GEN_CALL_ADDR);
  endfunction

endpackage

// File: core/ait_bus_if.sv
// Open-drain two-wire bus joining the converter target and its controller.
// Assumes each party only asserts an enable to pull a line low.
`timescale 1ns/1ps

interface ait_bus_if;
  logic tgt_scl_oe;
  logic tgt_sda_oe;
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: a line is high unless someone pulls it.
  assign scl = ~(tgt_scl_oe | ctl_scl_oe);
  assign sda = ~(tgt_sda_oe | ctl_sda_oe);

  modport target (
    input scl,
    input sda,
    output tgt_scl_oe,
    output tgt_sda_oe
  );

  modport ctrl (
    input scl,
    input sda,
    output ctl_scl_oe,
    output ctl_sda_oe
  );
endinterface // ait_bus_if

// File: core/ait_target.sv
// Serial target of the converter: bus byte engine in the system clock
// domain and the active-low ready output in the master clock domain.
// Assumes a command decoder on the byte ports and a conversion core on
// the master clock that announces each data update in advance.
`timescale 1ns/1ps

module ait_target (
  // Clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Two-wire bus
  ait_bus_if.target bus,
  // Byte stream, system clock
  output logic o_start,
  output logic o_stop,
  output logic o_rx_valid,
  output logic [ait_pkg::BYTE_W-1:0] o_rx_data,
  output logic o_tx_load,
  input wire logic [ait_pkg::BYTE_W-1:0] i_tx_data,
  output logic o_nack,
  // Read completion, system clock
  input wire logic i_data_read_done,
  // Conversion core, master clock
  input wire logic i_update_pending,
  output logic o_data_update,
  output logic o_conversion_ready_n
);
  import ait_pkg::*;

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  ait_tgt_st_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic nack_r;
  logic sda_oe_r;
  logic byte_end;
  logic load_tx;
  logic rd_tgl_r;
  logic [1:0] mrst_r;
  logic m_rstn;
  logic [2:0] rd_sync_r;
  logic rd_evt;
  logic [2:0] pre_cnt_r;
  logic pre_busy_r;
  logic pre_last;

  // Both pins pass two flip-flops; only the second stage is read onward.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'h1;
      sda_prev_r <= 1'h1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], bus.scl};
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  // Edge and condition decode on the synchronised lines.
  assign scl_now = scl_sync_r[1];
  assign sda_now = sda_sync_r[1];
  assign scl_rise = scl_now && !scl_prev_r;
  assign scl_fall = !scl_now && scl_prev_r;
  // Both samples need a high clock, so a data edge with clock low is data.
  assign start_det = scl_now && scl_prev_r && sda_prev_r && !sda_now;
  assign stop_det = scl_now && scl_prev_r && !sda_prev_r && sda_now;

  // Byte boundary and transmit reload, shared by the state machine and
  // the stream outputs so both see the same moment.
  always_comb begin
    byte_end = scl_fall && (cnt_r == ACK_BIT) &&
               ((st_r == AIT_T_ADDR) || (st_r == AIT_T_RX));
    load_tx = scl_fall && (((st_r == AIT_T_ACK) && rw_r) ||
              ((st_r == AIT_T_TXACK) && !nack_r));
  end

  // Bus state machine. A start restarts it from any state, which also
  // covers the repeated start before a read.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_r <= AIT_T_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'h0;
      nack_r <= 1'h0;
      sda_oe_r <= 1'h0;
    end else if (start_det) begin
      st_r <= AIT_T_ADDR;
      cnt_r <= 4'h0;
      rw_r <= 1'h0;
      sda_oe_r <= 1'h0;
    end else if (stop_det) begin
      st_r <= AIT_T_IDLE;
      sda_oe_r <= 1'h0;
    end else begin
      case (st_r)
        AIT_T_IDLE: begin
          sda_oe_r <= 1'h0;
        end
        AIT_T_ADDR, AIT_T_RX: begin
          if (scl_rise && (cnt_r != ACK_BIT)) begin
            shift_r <= {shift_r[6:0], sda_now};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            if (st_r == AIT_T_RX) begin
              sda_oe_r <= 1'h1;
              st_r <= AIT_T_ACK;
            end else if (ait_addr_hit(shift_r, TGT_ADDR)) begin
              sda_oe_r <= 1'h1;
              rw_r <= shift_r[0];
              st_r <= AIT_T_ACK;
            end else begin
              st_r <= AIT_T_IDLE;
            end
          end
        end
        AIT_T_ACK: begin
          // The acknowledge ends on the falling clock after it.
          if (load_tx) begin
            shift_r <= i_tx_data;
            sda_oe_r <= ~i_tx_data[7];
            cnt_r <= 4'h0;
            st_r <= AIT_T_TX;
          end else if (scl_fall) begin
            sda_oe_r <= 1'h0;
            cnt_r <= 4'h0;
            st_r <= AIT_T_RX;
          end
        end
        AIT_T_TX: begin
          if (scl_fall) begin
            if (cnt_r == LAST_BIT) begin
              sda_oe_r <= 1'h0;
              st_r <= AIT_T_TXACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'h0};
              sda_oe_r <= ~shift_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        AIT_T_TXACK: begin
          if (scl_rise) begin
            nack_r <= sda_now;
          end else if (load_tx) begin
            shift_r <= i_tx_data;
            sda_oe_r <= ~i_tx_data[7];
            cnt_r <= 4'h0;
            st_r <= AIT_T_TX;
          end else if (scl_fall) begin
            st_r <= AIT_T_IDLE;
          end
        end
        default: begin
          st_r <= AIT_T_IDLE;
          sda_oe_r <= 1'h0;
        end
      endcase
    end
  end

  // The target never drives the clock, so no wait state can be inserted.
  assign bus.tgt_scl_oe = 1'h0;
  assign bus.tgt_sda_oe = sda_oe_r;

  // Stream outputs: one-cycle pulses and the held received byte, all from flip-flops.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_start <= 1'h0;
      o_stop <= 1'h0;
      o_rx_valid <= 1'h0;
      o_rx_data <= 8'h00;
      o_tx_load <= 1'h0;
      o_nack <= 1'h0;
    end else begin
      o_start <= start_det;
      o_stop <= stop_det && (st_r != AIT_T_IDLE);
      o_rx_valid <= byte_end && (st_r == AIT_T_RX) && !start_det &&
                    !stop_det;
      if (byte_end && (st_r == AIT_T_RX)) begin
        o_rx_data <= shift_r;
      end
      o_tx_load <= load_tx && !start_det && !stop_det;
      o_nack <= scl_fall && (st_r == AIT_T_TXACK) && nack_r &&
                !start_det && !stop_det;
    end
  end

  // Read completion is a system clock pulse; a toggle carries it across.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_tgl_r <= 1'h0;
    end else if (i_data_read_done) begin
      rd_tgl_r <= ~rd_tgl_r;
    end
  end

  // Reset is brought into the master clock domain; it takes two master
  // clock edges to reach the ready logic, so hold it long enough.
  always_ff @(posedge i_mclk) begin
    mrst_r <= {mrst_r[0], i_rstn};
  end
  assign m_rstn = mrst_r[1];

  // Toggle synchroniser; the edge detector reads only the later stages.
  always_ff @(posedge i_mclk) begin
    if (!m_rstn) begin
      // Constant reset keeps the crossing signal out of the later stages.
      rd_sync_r <= 3'h0;
    end else begin
      rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
    end
  end
  assign rd_evt = rd_sync_r[2] ^ rd_sync_r[1];
  assign pre_last = pre_busy_r && (pre_cnt_r == 3'h1);

  // Ready output. An announced update forces ready high, holds it four
  // master clocks, then writes the data and drops ready. A result still
  // unread at that point therefore yields the short high pulse.
  always_ff @(posedge i_mclk) begin
    if (!m_rstn) begin
      o_conversion_ready_n <= 1'h1;
      o_data_update <= 1'h0;
      pre_cnt_r <= 3'h0;
      pre_busy_r <= 1'h0;
    end else begin
      o_data_update <= pre_last;
      if (i_update_pending) begin
        o_conversion_ready_n <= 1'h1;
        pre_cnt_r <= PRE_UPDATE_MCLK;
        pre_busy_r <= 1'h1;
      end else if (pre_last) begin
        o_conversion_ready_n <= 1'h0;
        pre_busy_r <= 1'h0;
        pre_cnt_r <= 3'h0;
      end else begin
        if (pre_busy_r) begin
          pre_cnt_r <= pre_cnt_r - 3'h1;
        end
        if (rd_evt) begin
          o_conversion_ready_n <= 1'h1;
        end
      end
    end
  end

endmodule // ait_target

// File: core/ait_controller.sv
// Bus controller end: turns start, write, read and stop commands into
// open-drain clock and data activity at up to 1 Mbit/s.
// Assumes its commands come from logic on the same system clock and that
// the target never stretches the clock.
`timescale 1ns/1ps

module ait_controller (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Two-wire bus
  ait_bus_if.ctrl bus,
  // Command port
  input wire logic i_cmd_valid,
  input wire ait_pkg::ait_cmd_e i_cmd,
  input wire logic [ait_pkg::BYTE_W-1:0] i_wdata,
  input wire logic i_ack_send,
  output logic o_cmd_ready,
  // Results
  output logic o_done,
  output logic [ait_pkg::BYTE_W-1:0] o_rdata,
  output logic o_ack_seen
);
  import ait_pkg::*;

  logic [1:0] sda_sync_r;
  logic sda_now;
  ait_ctl_st_e st_r;
  logic rd_r;
  logic ack_send_r;
  logic [5:0] qtr_r;
  logic tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic scl_oe_r;
  logic sda_oe_r;

  // The data pin crosses in through two flip-flops before it is sampled.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
    end
  end
  assign sda_now = sda_sync_r[1];

  // Quarter-period timer; it only runs while a command is in flight.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || (st_r == AIT_C_IDLE) || tick) begin
      qtr_r <= 6'h00;
    end else begin
      qtr_r <= qtr_r + 6'h01;
    end
  end
  assign tick = (st_r != AIT_C_IDLE) && (qtr_r == QTR_LAST);

  // Command sequencer. Each command takes four quarters per bit; the
  // data line is set a quarter after the clock falls and sampled a
  // quarter after it rises, leaving margin for the synchroniser delay.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_r <= AIT_C_IDLE;
      rd_r <= 1'h0;
      ack_send_r <= 1'h0;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      scl_oe_r <= 1'h0;
      sda_oe_r <= 1'h0;
      o_done <= 1'h0;
      o_rdata <= 8'h00;
      o_ack_seen <= 1'h0;
    end else begin
      o_done <= 1'h0;
      case (st_r)
        AIT_C_IDLE: begin
          if (i_cmd_valid) begin
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            shift_r <= i_wdata;
            rd_r <= (i_cmd == AIT_CMD_READ);
            ack_send_r <= i_ack_send;
            case (i_cmd)
              AIT_CMD_START: st_r <= AIT_C_START;
              AIT_CMD_STOP: st_r <= AIT_C_STOP;
              default: st_r <= AIT_C_BIT;
            endcase
          end
        end
        AIT_C_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'h0;
              2'h1: scl_oe_r <= 1'h0;
              2'h2: sda_oe_r <= 1'h1;
              default: begin
                scl_oe_r <= 1'h1;
                st_r <= AIT_C_IDLE;
                o_done <= 1'h1;
              end
            endcase
          end
        end
        AIT_C_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'h1;
              2'h1: scl_oe_r <= 1'h0;
              2'h2: sda_oe_r <= 1'h0;
              default: begin
                st_r <= AIT_C_IDLE;
                o_done <= 1'h1;
              end
            endcase
          end
        end
        AIT_C_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: begin
                // Clock is low here, so changing data is safe.
                if (bit_r == ACK_BIT) begin
                  sda_oe_r <= rd_r && ack_send_r;
                end else begin
                  sda_oe_r <= !rd_r && !shift_r[7];
                end
              end
              2'h1: scl_oe_r <= 1'h0;
              2'h2: begin
                if (bit_r == ACK_BIT) begin
                  o_ack_seen <= !sda_now;
                end else begin
                  shift_r <= {shift_r[6:0], sda_now};
                end
              end
              default: begin
                scl_oe_r <= 1'h1;
                if (bit_r == ACK_BIT) begin
                  sda_oe_r <= 1'h0;
                  o_rdata <= shift_r;
                  st_r <= AIT_C_IDLE;
                  o_done <= 1'h1;
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
        end
        default: begin
          st_r <= AIT_C_IDLE;
        end
      endcase
    end
  end

  assign bus.ctl_scl_oe = scl_oe_r;
  assign bus.ctl_sda_oe = sda_oe_r;
  assign o_cmd_ready = (st_r == AIT_C_IDLE);

endmodule // ait_controller

// File: sim/ait_bus_properties.sv
// Concurrent checks on the shared two-wire bus and the ready output.
// Assumes it sits beside the bus interface in the bench top module.
`timescale 1ns/1ps

module ait_bus_properties (
  // Clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Bus enables and levels
  input wire logic tgt_scl_oe,
  input wire logic tgt_sda_oe,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic scl,
  input wire logic sda,
  // Ready path
  input wire logic i_update_pending,
  input wire logic o_data_update,
  input wire logic o_conversion_ready_n
);
  // Every low clock belongs to the controller, so no wait states appear.
  no_stretch_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !scl |-> ctl_scl_oe && !tgt_scl_oe) else $error("clock held by target");
  tgt_data_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $changed(tgt_sda_oe) |-> !scl && !$past(scl))
    else $error("target data moved near high clock");
  scl_low_min_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $fell(scl) |=> !scl [*8]) else $error("clock low too short");
  scl_high_min_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(scl) |=> scl [*8]) else $error("clock high too short");
  start_by_ctl_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    scl && $past(scl) && $fell(sda) |-> ctl_sda_oe && !tgt_sda_oe)
    else $error("start not made by controller");
  stop_clean_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    scl && $past(scl) && $rose(sda) |-> !tgt_sda_oe)
    else $error("target held data at stop");
  // The slow side: ready must lead each data update by four cycles.
  ready_lead_a: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    i_update_pending |=> o_conversion_ready_n [*4] ##1
    (o_data_update && !o_conversion_ready_n))
    else $error("ready lead wrong");
  update_ready_a: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    o_data_update |-> !o_conversion_ready_n && $past(o_conversion_ready_n))
    else $error("ready not low at update");
endmodule // ait_bus_properties

// File: sim/adc_i2c_target_with_data_ready_tb_top.sv
// Bench joining the serial target and the bus controller over one bus.
// Assumes the package constants; stimulus changes on falling edges.
`timescale 1ns/1ps

module adc_i2c_target_with_data_ready_tb_top;
  import ait_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_cmd_valid = 1'b0;
  ait_cmd_e i_cmd = AIT_CMD_START;
  logic [7:0] i_wdata = 8'h00;
  logic i_ack_send = 1'b1;
  logic i_data_read_done = 1'b0;
  logic i_update_pending = 1'b0;
  logic [7:0] i_tx_data;
  logic [7:0] txv [4];
  logic [7:0] o_rdata, o_rx_data;
  logic o_cmd_ready, o_done, o_ack_seen, o_start, o_stop, o_rx_valid;
  logic o_tx_load, o_nack, o_data_update, o_conversion_ready_n;
  logic [31:0] seed = 32'h00006FB1;
  logic [7:0] rxq [$];
  int n_fail = 0;
  int compares = 0;
  int n_st = 0;
  int n_sp = 0;
  int n_nk = 0;
  int tx_idx = 0;

  ait_bus_if bus ();
  ait_target u_ait_target (.i_sys_clk(i_sys_clk), .i_mclk(i_mclk),
    .i_rstn(i_rstn), .bus(bus.target), .o_start(o_start), .o_stop(o_stop),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_tx_load(o_tx_load),
    .i_tx_data(i_tx_data), .o_nack(o_nack),
    .i_data_read_done(i_data_read_done),
    .i_update_pending(i_update_pending), .o_data_update(o_data_update),
    .o_conversion_ready_n(o_conversion_ready_n));
  ait_controller u_ait_controller (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .bus(bus.ctrl), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_wdata(i_wdata), .i_ack_send(i_ack_send), .o_cmd_ready(o_cmd_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_ack_seen(o_ack_seen));
  ait_bus_properties u_ait_bus_properties (.i_sys_clk(i_sys_clk),
    .i_mclk(i_mclk), .i_rstn(i_rstn), .tgt_scl_oe(bus.tgt_scl_oe),
    .tgt_sda_oe(bus.tgt_sda_oe), .ctl_scl_oe(bus.ctl_scl_oe),
    .ctl_sda_oe(bus.ctl_sda_oe), .scl(bus.scl), .sda(bus.sda),
    .i_update_pending(i_update_pending), .o_data_update(o_data_update),
    .o_conversion_ready_n(o_conversion_ready_n));

  // Two unrelated clocks; the master clock starts off a fractional phase.
  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #3.3;
    forever #40 i_mclk = ~i_mclk;
  end

  // The read byte source advances once the target has taken a byte.
  assign i_tx_data = txv[tx_idx[1:0]];
  always @(negedge i_sys_clk) begin
    if (o_tx_load) tx_idx <= tx_idx + 1;
  end

  // Target pulses are counted here and compared later by the main flow.
  always @(posedge i_sys_clk) begin
    if (o_start) n_st++;
    if (o_stop) n_sp++;
    if (o_nack) n_nk++;
    if (o_rx_valid) rxq.push_back(o_rx_data);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Only the own seven-bit address is answered, never the general call.
  function automatic logic exp_ack(input logic [7:0] a);
    return (a[7:1] == TGT_ADDR) && (a[7:1] != 7'h00);
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One command, offered for one clock after ready is checked, then a bounded wait for completion.
  task automatic cmd(input ait_cmd_e c, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    chk("cmd_ready", o_cmd_ready, 1'b1);
    i_cmd_valid = 1'b1;
    i_cmd = c;
    i_wdata = d;
    i_ack_send = a;
    @(negedge i_sys_clk);
    i_cmd_valid = 1'b0;
    while (o_done !== 1'b1 && n < 2000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("done", o_done, 1'b1);
  endtask

  task automatic wr(input logic [7:0] d, input logic ack);
    cmd(AIT_CMD_WRITE, d, 1'b1);
    chk("ack", o_ack_seen, ack);
    chk("echo", o_rdata, d);
  endtask

  task automatic getrx(input logic [7:0] exp);
    int n;
    for (n = 0; n < 30 && rxq.size() == 0; n++) @(posedge i_sys_clk);
    chk("rx", (rxq.size() > 0) ? rxq.pop_front() : 8'hXX, exp);
  endtask

  // Result update seen through the ready output on the master clock.
  task automatic upd;
    @(negedge i_mclk);
    i_update_pending = 1'b1;
    @(negedge i_mclk);
    i_update_pending = 1'b0;
    chk("rdy_lead", o_conversion_ready_n, 1'b1);
    repeat (5) @(negedge i_mclk);
    chk("rdy_low", o_conversion_ready_n, 1'b0);
  endtask

  initial begin
    logic [7:0] b;
    int k;
    // Held long enough for the master clock side to see reset.
    repeat (48) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      txv[k] = seed[7:0];
    end
    // The ready logic leaves reset two master clocks after the bus side.
    repeat (4) @(negedge i_mclk);
    chk("rdy_idle", o_conversion_ready_n, 1'b1);
    upd();
    @(negedge i_sys_clk);
    i_data_read_done = 1'b1;
    @(negedge i_sys_clk);
    i_data_read_done = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk("rdy_read", o_conversion_ready_n, 1'b1);
    upd();
    upd();
    // Write: own address, then random bytes with both extremes first.
    cmd(AIT_CMD_START, 8'h00, 1'b1);
    chk("starts", 8'(n_st), 8'h01);
    wr(8'h60, 1'b1);
    for (k = 0; k < 6; k++) begin
      seed = xs(seed);
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
      wr(b, 1'b1);
      getrx(b);
    end
    cmd(AIT_CMD_STOP, 8'h00, 1'b1);
    chk("stops", 8'(n_sp), 8'h01);
    // Foreign and general-call addresses are ignored to the stop.
    seed = xs(seed);
    b = seed[7:0];
    if (b[7:1] == TGT_ADDR) b = b ^ 8'h80;
    for (k = 0; k < 2; k++) begin
      cmd(AIT_CMD_START, 8'h00, 1'b1);
      wr(k == 0 ? 8'h00 : b, exp_ack(k == 0 ? 8'h00 : b));
      wr(8'h5A, 1'b0);
      cmd(AIT_CMD_STOP, 8'h00, 1'b1);
    end
    chk("rx_none", 8'(rxq.size()), 8'h00);
    chk("stops_idle", 8'(n_sp), 8'h01);
    // Read after a repeated start, the last byte declined.
    cmd(AIT_CMD_START, 8'h00, 1'b1);
    wr(8'h60, 1'b1);
    wr(8'hC3, 1'b1);
    getrx(8'hC3);
    cmd(AIT_CMD_START, 8'h00, 1'b1);
    wr(8'h61, 1'b1);
    for (k = 0; k < 3; k++) begin
      cmd(AIT_CMD_READ, 8'h00, k < 2);
      chk("rdata", o_rdata, txv[k]);
    end
    // The target sees the last falling clock a few cycles after done.
    repeat (8) @(negedge i_sys_clk);
    chk("nacks", 8'(n_nk), 8'h01);
    wr(8'h60, 1'b0);
    cmd(AIT_CMD_STOP, 8'h00, 1'b1);
    chk("starts_all", 8'(n_st), 8'h05);
    chk("stops_nack", 8'(n_sp), 8'h01);
    close_out();
  end

  // A hang counts against the run and ends it through the same exit.
  initial begin
    // About twice the length of the whole command sequence.
    #400000;
    n_fail++;
    close_out();
  end

  task automatic close_out;
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule // adc_i2c_target_with_data_ready_tb_top
